// *** logic/tsta_map.svh ***
`ifndef TSTA_MAP_SVH
`define TSTA_MAP_SVH
// Functional notes
// - general iso packets readable whole at iso_rx_fifo_port
// - eight receive ports, port 0 for cells
// - port 0 receives only when control bit 24
// - copy header and trailer per format
// - set per-format receive-available flag after buffering
// - header select bypasses timestamp and aging
// - first line marks first quadlet of cell
// - processor reads bulky FIFO at first_fmt_bulk_rx_fifo/second_fmt_bulk_rx_fifo
// - header select and direct out pick mode
// - capture bus header and both cip headers
// - output-available when timestamp equals cycle timer
// - cell-only mode stores cell data only
// - processor read allowed only after release
// - transmit stamp is cycle timer plus offset
// - receive stamp plus offset released on match
// - receive aging flushes packets older than timer
// - transmit aging discards expired queued packet
// - bits 6,7 aging, bit 29 auto stamp
// - offset registers at First_fmt_tx_ts_offset DCh, then E0h E4h E8h
// - transmit offset adds bits 7-31 unless extended
// - stamp fields seconds, cycles, offset in range
// - offset above 3071 carries into cycle count
// - count above 7999 carries into seconds
// - bad transmit offset fields truncate to maximum
`define TSTA_A_CTL 12'h00c
`define TSTA_A_CYC 12'h028
`define TSTA_A_TXO0 12'h0dc
`define TSTA_A_TXO1 12'h0e0
`define TSTA_A_RXO0 12'h0e4
`define TSTA_A_RXO1 12'h0e8
`define TSTA_A_TSC0 12'h0f0
`define TSTA_A_TSC1 12'h0f4
`define TSTA_A_ISOF 12'h13c
`define TSTA_A_BLK0 12'h168
`define TSTA_A_BLK1 12'h174
`define TSTA_A_HDR0 12'h178
`define TSTA_A_TRL0 12'h184
`define TSTA_A_HDR1 12'h188
`define TSTA_A_TRL1 12'h194
`define TSTA_A_XINT 12'h1a0
// msb-first bit numbering: printed bit n sits at vector bit 31-n
`define TSTA_B(n) (31-(n))
`define TSTA_B_RX0ON `TSTA_B(24)
`define TSTA_B_ISO_RX_ON `TSTA_B(25)
`define TSTA_B_TXAGE `TSTA_B(6)
`define TSTA_B_RXAGE `TSTA_B(7)
`define TSTA_B_EXT `TSTA_B(17)
`define TSTA_B_AUTO `TSTA_B(29)
`define TSTA_B_HSEL `TSTA_B(31)
`define TSTA_B_DOUT `TSTA_B(30)
`define TSTA_OFF_MAX 12'hbff
`define TSTA_OFF_WRAP 13'h0c00
`define TSTA_CNT_MAX 13'h1f3f
`define TSTA_CNT_WRAP 14'h1f40
`define TSTA_ADD_MASK 32'h01ff_ffff
`define TSTA_TS_Q 3'h3
`endif

// *** logic/tsta_pkg.sv ***
package tsta_pkg;
    typedef enum logic [1:0] {RX_IDLE, RX_HDR, RX_DATA, RX_DROP} tsta_rxst_t;
endpackage : tsta_pkg

// *** logic/tsta_top.sv ***
// Implementation choice: register access over APB.
`timescale 1ns/1ps
`include "tsta_map.svh"
module tsta_top #(
    parameter int DEPTH = 64,
    parameter int PKTS = 4
) (
    input wire logic ref_clk,
    input wire logic resetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic cycTick,
    input wire logic rxValid,
    input wire logic [31:0] rxData,
    input wire logic rxLast,
    input wire logic [2:0] rxPort,
    input wire logic rxFmt,
    output logic streamOutAvailable,
    output logic bulkStreamValid,
    output logic [31:0] bulkStreamData,
    output logic bulkStreamFirst,
    output logic bulkStreamFmt,
    input wire logic bulkStreamReady,
    input wire logic txFmt,
    output logic [31:0] txStamp,
    output logic txStampOn,
    input wire logic [31:0] txAgeTs,
    output logic txAgeDrop
);
    localparam int AW = $clog2(DEPTH);
    localparam int PW = $clog2(PKTS);

    if (DEPTH < 8 || (DEPTH & (DEPTH - 1)) != 0
            || PKTS < 2 || (PKTS & (PKTS - 1)) != 0) begin : g_chk
        $error("DEPTH and PKTS must be powers of two");
    end

    // ==========================================================
    // state
    typedef struct packed {
        logic [31:0] ctl;
        logic [31:0] cyc;
        logic [1:0][31:0] txTsOff;
        logic [1:0][31:0] rxTsOff;
        logic [1:0][31:0] tsc;
        logic [1:0][3:0][31:0] hdr;
        logic [1:0] irq;
        logic [2:0] sy;
        logic tk;
        tsta_pkg::tsta_rxst_t st;
        logic [2:0] qi;
        logic ki;
        logic kf;
        logic keep;
        logic byp;
        logic bad;
        logic fp;
        logic [31:0] ts;
        logic [AW:0] wp;
        logic [AW:0] wb;
        logic [AW:0] rp;
        logic [DEPTH-1:0][33:0] mem;
        logic [PKTS-1:0][31:0] dts;
        logic [PKTS-1:0][1:0] dk;
        logic [PKTS-1:0] db;
        logic [PW:0] dw;
        logic [PW:0] dr;
        logic rel;
        logic fl;
        logic ov;
        logic [31:0] od;
        logic of;
        logic ofm;
        logic avail;
        logic rdy;
        logic pop;
        logic err;
        logic [31:0] rd;
        logic [31:0] txs;
        logic txon;
        logic txd;
    } tsta_state_t;

    tsta_state_t q_r;
    tsta_state_t q_nxt;

    // ==========================================================
    // timestamp arithmetic: seconds [31:25], count [24:12], offset [11:0]
    function automatic logic [31:0] tsAdd(input logic [31:0] a, input logic [31:0] b);
        logic [12:0] o;
        logic [13:0] c;
        logic [6:0] s;
        logic co;
        logic cc;
        o = {1'b0, a[11:0]} + {1'b0, b[11:0]};
        co = o > {1'b0, `TSTA_OFF_MAX};
        if (co) o = o - `TSTA_OFF_WRAP;
        c = {1'b0, a[24:12]} + {1'b0, b[24:12]} + {13'h0, co};
        cc = c > {1'b0, `TSTA_CNT_MAX};
        if (cc) c = c - `TSTA_CNT_WRAP;
        s = a[31:25] + b[31:25] + {6'h0, cc};
        return {s, c[12:0], o[11:0]};
    endfunction : tsAdd

    function automatic logic [31:0] txClamp(input logic [31:0] x, input logic ext);
        logic [31:0] y;
        y = ext ? x : (x & `TSTA_ADD_MASK);
        if (y[24:12] > `TSTA_CNT_MAX) y[24:12] = `TSTA_CNT_MAX;
        if (y[11:0] > `TSTA_OFF_MAX) y[11:0] = `TSTA_OFF_MAX;
        return y;
    endfunction : txClamp

    // ==========================================================
    // next state
    always_comb begin
        logic stab;
        logic tick;
        logic setup;
        logic acc;
        logic full;
        logic dne;
        logic dfull;
        logic hiso;
        logic hf;
        logic hdir;
        logic cpuOk;
        logic strOk;
        logic popA;
        logic popS;
        logic wr;
        logic cm;
        logic [33:0] e;
        logic [33:0] hd;
        logic [31:0] rv;
        logic [11:0] ho0;
        logic [11:0] ho1;
        logic [PW-1:0] hi;
        logic f;
        q_nxt = q_r;
        stab = q_r.tk;
        tick = 1'b0;
        wr = 1'b0;
        cm = 1'b0;
        popS = 1'b0;
        e = 34'h0;
        rv = 32'h0;
        f = q_r.kf;
        q_nxt.rdy = 1'b0;
        q_nxt.err = 1'b0;
        q_nxt.pop = 1'b0;

        // cycle timer advances on a filtered pin tick
        q_nxt.sy = {q_r.sy[1:0], cycTick};
        if (q_r.sy[1] == q_r.sy[2]) stab = q_r.sy[2];
        q_nxt.tk = stab;
        tick = stab & ~q_r.tk;
        if (tick) q_nxt.cyc = tsAdd(q_r.cyc, 32'h0000_0001);

        hd = q_r.mem[q_r.rp[AW-1:0]];
        hi = q_r.dr[PW-1:0];
        hiso = q_r.dk[hi][1];
        hf = q_r.dk[hi][0];
        hdir = q_r.tsc[hf][`TSTA_B_DOUT];
        full = (q_r.wp[AW-1:0] == q_r.rp[AW-1:0]) && (q_r.wp[AW] != q_r.rp[AW]);
        dne = q_r.dw != q_r.dr;
        dfull = (q_r.dw[PW-1:0] == q_r.dr[PW-1:0]) && (q_r.dw[PW] != q_r.dr[PW]);
        cpuOk = q_r.rel & ~q_r.fl & ~hiso & ~hdir;
        strOk = q_r.rel & ~q_r.fl & ~hiso & hdir;

        // ======================================================
        // apb: decode at setup, act at the completing edge
        setup = psel & ~penable & ~q_r.rdy;
        acc = psel & penable & q_r.rdy;
        ho0 = paddr - `TSTA_A_HDR0;
        ho1 = paddr - `TSTA_A_HDR1;
        if (setup) begin
            q_nxt.rdy = 1'b1;
            if (paddr == `TSTA_A_CTL) rv = q_r.ctl;
            else if (paddr == `TSTA_A_CYC) rv = q_r.cyc;
            else if (paddr == `TSTA_A_TXO0) rv = q_r.txTsOff[0];
            else if (paddr == `TSTA_A_TXO1) rv = q_r.txTsOff[1];
            else if (paddr == `TSTA_A_RXO0) rv = q_r.rxTsOff[0];
            else if (paddr == `TSTA_A_RXO1) rv = q_r.rxTsOff[1];
            else if (paddr == `TSTA_A_TSC0) rv = q_r.tsc[0];
            else if (paddr == `TSTA_A_TSC1) rv = q_r.tsc[1];
            else if (paddr == `TSTA_A_XINT) rv = {30'h0, q_r.irq};
            else if (paddr >= `TSTA_A_HDR0 && paddr <= `TSTA_A_TRL0 && paddr[1:0] == 2'h0)
                rv = q_r.hdr[0][ho0[3:2]];
            else if (paddr >= `TSTA_A_HDR1 && paddr <= `TSTA_A_TRL1 && paddr[1:0] == 2'h0)
                rv = q_r.hdr[1][ho1[3:2]];
            else if (paddr == `TSTA_A_ISOF) begin
                if (q_r.rel & ~q_r.fl & hiso) begin
                    rv = hd[31:0];
                    q_nxt.pop = ~pwrite;
                end
            end else if (paddr == `TSTA_A_BLK0) begin
                if (cpuOk & ~hf) begin
                    rv = hd[31:0];
                    q_nxt.pop = ~pwrite;
                end
            end else if (paddr == `TSTA_A_BLK1) begin
                if (cpuOk & hf) begin
                    rv = hd[31:0];
                    q_nxt.pop = ~pwrite;
                end
            end else q_nxt.err = 1'b1;
            q_nxt.rd = rv;
        end
        if (acc & pwrite) begin
            if (paddr == `TSTA_A_CTL) q_nxt.ctl = pwdata;
            else if (paddr == `TSTA_A_CYC) q_nxt.cyc = pwdata;
            else if (paddr == `TSTA_A_TXO0) q_nxt.txTsOff[0] = pwdata;
            else if (paddr == `TSTA_A_TXO1) q_nxt.txTsOff[1] = pwdata;
            else if (paddr == `TSTA_A_RXO0) q_nxt.rxTsOff[0] = pwdata;
            else if (paddr == `TSTA_A_RXO1) q_nxt.rxTsOff[1] = pwdata;
            else if (paddr == `TSTA_A_TSC0) q_nxt.tsc[0] = pwdata;
            else if (paddr == `TSTA_A_TSC1) q_nxt.tsc[1] = pwdata;
            else if (paddr == `TSTA_A_XINT) q_nxt.irq = q_r.irq & ~pwdata[1:0];
        end
        // pop only what the setup edge handed out, even if release lands mid-transfer
        popA = acc & q_r.pop;

        // ======================================================
        // bulk stream port
        if (q_r.ov & bulkStreamReady) q_nxt.ov = 1'b0;
        if ((~q_r.ov | bulkStreamReady) & strOk) begin
            q_nxt.ov = 1'b1;
            q_nxt.od = hd[31:0];
            q_nxt.of = hd[32];
            q_nxt.ofm = hf;
            popS = 1'b1;
        end
        // stays up while the last word of a packet waits on the sink
        q_nxt.avail = strOk | q_nxt.ov;

        // released head drains by reads, the stream, or a flush
        if (popA | popS | q_r.fl) begin
            q_nxt.rp = q_r.rp + 1'b1;
            if (hd[33]) begin
                q_nxt.dr = q_r.dr + 1'b1;
                q_nxt.rel = 1'b0;
                q_nxt.fl = 1'b0;
            end
        end
        if (~q_r.rel & dne) begin
            if (hiso | q_r.db[hi] | (q_r.dts[hi] == q_r.cyc)) q_nxt.rel = 1'b1;
            else if (q_r.tsc[hf][`TSTA_B_RXAGE] && q_r.dts[hi] < q_r.cyc) begin
                q_nxt.rel = 1'b1;
                q_nxt.fl = 1'b1;
            end
        end

        // ======================================================
        // capture: q0 bus header, q1-q2 cip, q3 stamp, data, trailer
        case (q_r.st)
            tsta_pkg::RX_IDLE: begin
                if (rxValid & ~rxLast) begin
                    q_nxt.kf = rxFmt;
                    q_nxt.ki = rxPort != 3'h0;
                    q_nxt.wb = q_r.wp;
                    q_nxt.qi = 3'h1;
                    q_nxt.bad = 1'b0;
                    q_nxt.fp = 1'b1;
                    q_nxt.keep = (rxPort != 3'h0) | q_r.tsc[rxFmt][`TSTA_B_HSEL];
                    q_nxt.byp = q_r.tsc[rxFmt][`TSTA_B_HSEL];
                    if (dfull) q_nxt.st = tsta_pkg::RX_DROP;
                    else if (rxPort == 3'h0 && !q_r.ctl[`TSTA_B_RX0ON])
                        q_nxt.st = tsta_pkg::RX_DROP;
                    else if (rxPort != 3'h0 && !q_r.ctl[`TSTA_B_ISO_RX_ON])
                        q_nxt.st = tsta_pkg::RX_DROP;
                    else begin
                        if (rxPort == 3'h0) begin
                            q_nxt.st = tsta_pkg::RX_HDR;
                            q_nxt.hdr[rxFmt][0] = rxData;
                        end else q_nxt.st = tsta_pkg::RX_DATA;
                        if (q_nxt.keep) begin
                            wr = 1'b1;
                            e = {2'b01, rxData};
                            q_nxt.fp = 1'b0;
                        end
                    end
                end
            end
            tsta_pkg::RX_HDR: begin
                if (rxValid) begin
                    if (rxLast) begin
                        // truncated packet: buffered words are undone, header copies stay
                        q_nxt.st = tsta_pkg::RX_IDLE;
                        q_nxt.wp = q_r.wb;
                    end else begin
                        if (q_r.qi == `TSTA_TS_Q) begin
                            q_nxt.ts = tsAdd(rxData, q_r.rxTsOff[f]);
                            q_nxt.st = tsta_pkg::RX_DATA;
                        end else q_nxt.hdr[f][q_r.qi[1:0]] = rxData;
                        if (q_r.keep) begin
                            wr = 1'b1;
                            e = {2'b00, rxData};
                        end
                        q_nxt.qi = q_r.qi + 3'h1;
                    end
                end
            end
            tsta_pkg::RX_DATA: begin
                if (rxValid & ~rxLast) begin
                    wr = 1'b1;
                    e = {1'b0, q_r.fp, rxData};
                    q_nxt.fp = 1'b0;
                end else if (rxValid) begin
                    q_nxt.st = tsta_pkg::RX_IDLE;
                    cm = 1'b1;
                    if (!q_r.ki) q_nxt.hdr[f][3] = rxData;
                    if (q_r.keep) begin
                        wr = 1'b1;
                        e = {2'b10, rxData};
                    end else if (q_r.fp) q_nxt.bad = 1'b1;
                    else q_nxt.mem[q_r.wp[AW-1:0] - 1'b1][33] = 1'b1;
                end
            end
            tsta_pkg::RX_DROP: begin
                if (rxValid & rxLast) q_nxt.st = tsta_pkg::RX_IDLE;
            end
            default: q_nxt.st = tsta_pkg::RX_IDLE;
        endcase
        // overflow spoils the packet rather than stalling the bus side
        if (wr) begin
            if (full) q_nxt.bad = 1'b1;
            else begin
                q_nxt.mem[q_r.wp[AW-1:0]] = e;
                q_nxt.wp = q_r.wp + 1'b1;
            end
        end
        if (cm) begin
            if (q_nxt.bad | (~q_r.ki & ~q_r.byp & q_r.tsc[f][`TSTA_B_RXAGE]
                & (q_r.ts < q_r.cyc))) q_nxt.wp = q_r.wb;
            else begin
                q_nxt.dts[q_r.dw[PW-1:0]] = q_r.ts;
                q_nxt.dk[q_r.dw[PW-1:0]] = {q_r.ki, f};
                q_nxt.db[q_r.dw[PW-1:0]] = q_r.byp;
                q_nxt.dw = q_r.dw + 1'b1;
                if (!q_r.ki) q_nxt.irq[f] = 1'b1;
            end
        end

        // ======================================================
        // transmit stamp and transmit aging
        q_nxt.txs = tsAdd(q_r.cyc,
            txClamp(q_r.txTsOff[txFmt], q_r.tsc[txFmt][`TSTA_B_EXT]));
        q_nxt.txon = q_r.tsc[txFmt][`TSTA_B_AUTO];
        q_nxt.txd = q_r.tsc[txFmt][`TSTA_B_TXAGE] && (txAgeTs < q_r.cyc);
    end

    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            q_r <= '0;
        end else begin
            q_r <= q_nxt;
        end
    end

    assign prdata = q_r.rd;
    assign pready = q_r.rdy;
    assign pslverr = q_r.err;
    assign streamOutAvailable = q_r.avail;
    assign bulkStreamValid = q_r.ov;
    assign bulkStreamData = q_r.od;
    assign bulkStreamFirst = q_r.of;
    assign bulkStreamFmt = q_r.ofm;
    assign txStamp = q_r.txs;
    assign txStampOn = q_r.txon;
    assign txAgeDrop = q_r.txd;
endmodule : tsta_top

// *** bench/tsta_chk.sv ***
`timescale 1ns/1ps
// ==========
// port checker
module tsta_chk #(
    parameter int DEPTH = 64,
    parameter int PKTS = 4
) (
    input wire logic ref_clk,
    input wire logic resetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic streamOutAvailable,
    input wire logic bulkStreamValid,
    input wire logic [31:0] bulkStreamData,
    input wire logic bulkStreamFirst,
    input wire logic bulkStreamFmt,
    input wire logic bulkStreamReady,
    input wire logic [31:0] txStamp,
    input wire logic txAgeDrop
);
    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (!resetn);
    property p_setup_answer;
        psel && !penable |=> pready;
    endproperty
    property p_ready_pulse;
        pready |=> !pready;
    endproperty
    property p_err_ready;
        pslverr |-> pready;
    endproperty
    property p_err_zero;
        pslverr && !pwrite |-> prdata == 32'h0;
    endproperty
    property p_hold;
        bulkStreamValid && !bulkStreamReady |=> bulkStreamValid && $stable(bulkStreamData)
            && $stable(bulkStreamFirst) && $stable(bulkStreamFmt);
    endproperty
    property p_valid_avail;
        bulkStreamValid |-> streamOutAvailable;
    endproperty
    property p_first_on_rise;
        $rose(streamOutAvailable) |-> bulkStreamValid && bulkStreamFirst;
    endproperty
    property p_stamp_range;
        txStamp[11:0] <= 12'hbff && txStamp[24:12] <= 13'h1f3f;
    endproperty
    a_setup_answer: assert property (p_setup_answer)
        else $error("no answer after setup");
    a_ready_pulse: assert property (p_ready_pulse)
        else $error("ready held past one cycle");
    a_err_ready: assert property (p_err_ready)
        else $error("error without ready");
    a_err_zero: assert property (p_err_zero)
        else $error("unmapped read not zero");
    a_hold: assert property (p_hold)
        else $error("stream word moved while stalled");
    a_valid_avail: assert property (p_valid_avail)
        else $error("stream valid without available");
    a_first_on_rise: assert property (p_first_on_rise)
        else $error("release not opened by first word");
    a_stamp_range: assert property (p_stamp_range)
        else $error("stamp field out of range");
    c_stream: cover property (bulkStreamValid && bulkStreamReady && bulkStreamFirst);
    c_err: cover property (pslverr);
    c_drop: cover property (txAgeDrop);
endmodule : tsta_chk

bind tsta_top tsta_chk #(.DEPTH(DEPTH), .PKTS(PKTS)) tsta_chk_inst (
    .ref_clk(ref_clk), .resetn(resetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .streamOutAvailable(streamOutAvailable), .bulkStreamValid(bulkStreamValid),
    .bulkStreamData(bulkStreamData), .bulkStreamFirst(bulkStreamFirst),
    .bulkStreamFmt(bulkStreamFmt), .bulkStreamReady(bulkStreamReady),
    .txStamp(txStamp), .txAgeDrop(txAgeDrop));

// *** bench/tsta_far.sv ***
`timescale 1ns/1ps
// ==========
// link sender and stream sink
module tsta_far (
    input wire logic ref_clk,
    output logic rxValid,
    output logic [31:0] rxData,
    output logic rxLast,
    output logic [2:0] rxPort,
    output logic rxFmt,
    input wire logic bulkStreamValid,
    input wire logic [31:0] bulkStreamData,
    input wire logic bulkStreamFirst,
    output logic bulkStreamReady
);
    localparam logic [31:0] HDR = 32'h0010_a0c0;
    localparam logic [31:0] C0 = 32'h0200_0001;
    localparam logic [31:0] C1 = 32'h8020_0000;
    localparam logic [31:0] TRL = 32'h0004_0000;
    localparam logic [31:0] DB = 32'hc000_0000;
    logic [31:0] rcv [32];
    logic fst [32];
    logic [31:0] lastQ = 32'h0;
    logic [1:0] stl = 2'h0;
    int rcvN = 0;
    initial begin
        rxValid = 1'h0;
        rxData = 32'h0;
        rxLast = 1'h0;
        rxPort = 3'h0;
        rxFmt = 1'h0;
        bulkStreamReady = 1'h0;
    end
    // stall one cycle in three so words wait under valid
    always @(posedge ref_clk) begin
        stl <= (stl == 2'h2) ? 2'h0 : stl + 2'h1;
        bulkStreamReady <= (stl != 2'h2);
        if (bulkStreamValid && bulkStreamReady) begin
            rcv[rcvN % 32] <= bulkStreamData;
            fst[rcvN % 32] <= bulkStreamFirst;
            rcvN <= rcvN + 1;
            lastQ <= bulkStreamData;
        end
    end
    task automatic send(input logic [2:0] p, input logic f, input logic [31:0] ts, input int n);
        logic [31:0] w [$];
        w = {HDR, C0, C1, ts};
        for (int k = 0; k < n; k++) w.push_back(DB + k);
        w.push_back(TRL);
        foreach (w[k]) begin
            rxValid <= 1'h1;
            rxData <= w[k];
            rxLast <= (k == w.size() - 1);
            rxPort <= p;
            rxFmt <= f;
            @(posedge ref_clk);
        end
        // released line shows the inverse, never the stale word
        rxValid <= 1'h0;
        rxLast <= 1'h0;
        rxData <= ~TRL;
        @(posedge ref_clk);
    endtask : send
endmodule : tsta_far

// *** bench/testbench.sv ***
`timescale 1ns/1ps
`include "tsta_map.svh"
module testbench;
    // ==========
    // harness
    logic ref_clk, resetn, psel, penable, pwrite, cycTick, txFmt, e;
    logic [11:0] paddr;
    logic [31:0] pwdata, txAgeTs, q;
    logic [1:0] f0;
    wire logic [31:0] prdata, rxData, bulkStreamData, txStamp;
    wire logic pready, pslverr, rxValid, rxLast, rxFmt, streamOutAvailable, txStampOn;
    wire logic bulkStreamValid, bulkStreamFirst, bulkStreamFmt, bulkStreamReady, txAgeDrop;
    wire logic [2:0] rxPort;
    int bad_count = 0;
    int n_checks = 0;
    int i;
    localparam logic [11:0] RW [8] = '{`TSTA_A_CTL, `TSTA_A_CYC, `TSTA_A_TXO0, `TSTA_A_TXO1,
        `TSTA_A_RXO0, `TSTA_A_RXO1, `TSTA_A_TSC0, `TSTA_A_TSC1};
    localparam logic [31:0] CA = {7'h01, 13'h1f3f, 12'hbff};
    localparam logic [31:0] CB = {7'h03, 13'h0010, 12'h100};
    tsta_top #(.DEPTH(64), .PKTS(4)) tsta_top_inst (.ref_clk(ref_clk), .resetn(resetn),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .cycTick(cycTick),
        .rxValid(rxValid), .rxData(rxData), .rxLast(rxLast), .rxPort(rxPort), .rxFmt(rxFmt),
        .streamOutAvailable(streamOutAvailable), .bulkStreamValid(bulkStreamValid),
        .bulkStreamData(bulkStreamData), .bulkStreamFirst(bulkStreamFirst),
        .bulkStreamFmt(bulkStreamFmt), .bulkStreamReady(bulkStreamReady), .txFmt(txFmt),
        .txStamp(txStamp), .txStampOn(txStampOn), .txAgeTs(txAgeTs), .txAgeDrop(txAgeDrop));
    tsta_far tsta_far_inst (.ref_clk(ref_clk), .rxValid(rxValid), .rxData(rxData),
        .rxLast(rxLast), .rxPort(rxPort), .rxFmt(rxFmt), .bulkStreamValid(bulkStreamValid),
        .bulkStreamData(bulkStreamData), .bulkStreamFirst(bulkStreamFirst),
        .bulkStreamReady(bulkStreamReady));
    initial begin
        ref_clk = 1'h0;
        forever #2 ref_clk = ~ref_clk;
    end
    // ==========
    // tasks
    task end_sim;
        if (bad_count == 0 && n_checks > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask : end_sim
    task chk(input logic [31:0] s, input logic [31:0] x);
        n_checks++;
        if (s !== x) begin
            bad_count++;
            $display("MISMATCH t=%0t seen %h expected %h", $time, s, x);
        end
    endtask : chk
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        int n;
        psel <= 1'h1;
        penable <= 1'h0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge ref_clk);
        penable <= 1'h1;
        n = 0;
        do begin
            @(posedge ref_clk);
            n++;
        end while (pready !== 1'h1 && n < 50);
        q = prdata;
        e = pslverr;
        psel <= 1'h0;
        penable <= 1'h0;
        chk({31'h0, pready}, 32'h1);
        if (pready !== 1'h1) end_sim;
        @(posedge ref_clk);
    endtask : apb
    task wr(input logic [11:0] a, input logic [31:0] d);
        apb(1'h1, a, d);
    endtask : wr
    task rd(input logic [11:0] a, input logic [31:0] x);
        apb(1'h0, a, 32'h0);
        chk(q, x);
    endtask : rd
    // bounded polling: a read port yields zero until its packet is released
    task automatic find(input logic [11:0] a, input logic [31:0] t);
        q = 32'h0;
        for (int k = 0; k < 8 && q !== t; k++) apb(1'h0, a, 32'h0);
        chk(q, t);
        if (q !== t) end_sim;
    endtask : find
    task automatic waitq(input logic [31:0] t);
        int k;
        for (k = 0; k < 300 && tsta_far_inst.lastQ !== t; k++) @(posedge ref_clk);
        chk(tsta_far_inst.lastQ, t);
        if (k == 300) end_sim;
    endtask : waitq
    task tick(input int n);
        repeat (n) begin
            cycTick <= 1'h1;
            repeat (4) @(posedge ref_clk);
            cycTick <= 1'h0;
            repeat (4) @(posedge ref_clk);
        end
    endtask : tick
    // ==========
    // sequence
    initial begin
        {resetn, psel, penable, pwrite, cycTick, txFmt} = 6'h0;
        paddr = 12'h0;
        pwdata = 32'h0;
        txAgeTs = 32'h0;
        repeat (8) @(posedge ref_clk);
        resetn <= 1'h1;
        @(posedge ref_clk);
        rd(`TSTA_A_TSC0, 32'h0);
        apb(1'h0, 12'h1fc, 32'h0);
        chk({31'h0, e}, 32'h1);
        for (i = 0; i < 8; i++) wr(RW[i], {7'(i), 13'(i), 12'(i + 1)});
        for (i = 0; i < 8; i++) rd(RW[i], {7'(i), 13'(i), 12'(i + 1)});
        for (i = 0; i < 8; i++) wr(RW[i], 32'h0);
        wr(`TSTA_A_CYC, CA);
        wr(`TSTA_A_TXO0, {7'h05, 13'h0, 12'h001});
        repeat (2) @(posedge ref_clk);
        chk(txStamp, {7'h02, 25'h0});
        wr(`TSTA_A_TSC0, 32'h0000_4004);
        repeat (2) @(posedge ref_clk);
        chk(txStamp, {7'h07, 25'h0});
        chk({31'h0, txStampOn}, 32'h1);
        txFmt <= 1'h1;
        txAgeTs <= CA - 32'h1;
        wr(`TSTA_A_TXO1, {7'h00, 13'h1fff, 12'hfff});
        wr(`TSTA_A_TSC1, 32'h0200_0000);
        repeat (2) @(posedge ref_clk);
        chk(txStamp, {7'h02, 13'h1f3f, 12'hbfe});
        chk({31'h0, txAgeDrop}, 32'h1);
        txAgeTs <= CA;
        repeat (2) @(posedge ref_clk);
        chk({31'h0, txAgeDrop}, 32'h0);
        wr(`TSTA_A_TSC1, 32'h0);
        tsta_far_inst.send(3'h0, 1'h0, 32'h0, 2);
        repeat (6) @(posedge ref_clk);
        rd(`TSTA_A_XINT, 32'h0);
        wr(`TSTA_A_CTL, 32'h0000_0080);
        wr(`TSTA_A_TSC0, 32'h0100_0003);
        tsta_far_inst.send(3'h0, 1'h0, 32'h0, 2);
        waitq(tsta_far_inst.TRL);
        chk(tsta_far_inst.rcv[0], tsta_far_inst.HDR);
        chk({31'h0, tsta_far_inst.fst[0]}, 32'h1);
        rd(`TSTA_A_HDR0, tsta_far_inst.HDR);
        rd(`TSTA_A_HDR0 + 12'h4, tsta_far_inst.C0);
        rd(`TSTA_A_HDR0 + 12'h8, tsta_far_inst.C1);
        rd(`TSTA_A_TRL0, tsta_far_inst.TRL);
        apb(1'h0, `TSTA_A_XINT, 32'h0);
        f0 = q[1:0];
        chk({31'h0, $onehot(f0)}, 32'h1);
        wr(`TSTA_A_XINT, 32'h3);
        wr(`TSTA_A_TSC0, 32'h2);
        wr(`TSTA_A_CYC, CB);
        wr(`TSTA_A_RXO0, 32'h2);
        tsta_far_inst.rcvN = 0;
        tsta_far_inst.send(3'h0, 1'h0, CB + 32'h3, 2);
        tick(4);
        chk({31'h0, streamOutAvailable}, 32'h0);
        tick(1);
        waitq(tsta_far_inst.DB + 32'h1);
        chk({31'h0, tsta_far_inst.fst[0]}, 32'h1);
        for (i = 0; i < tsta_far_inst.rcvN; i++)
            chk(tsta_far_inst.rcv[i] inside {tsta_far_inst.HDR, tsta_far_inst.TRL}, 0);
        wr(`TSTA_A_XINT, 32'h3);
        tsta_far_inst.send(3'h0, 1'h1, CB + 32'h7, 2);
        repeat (4) @(posedge ref_clk);
        rd(`TSTA_A_BLK1, 32'h0);
        rd(`TSTA_A_HDR1, tsta_far_inst.HDR);
        rd(`TSTA_A_TRL1, tsta_far_inst.TRL);
        rd(`TSTA_A_XINT, {30'h0, ~f0});
        tick(2);
        find(`TSTA_A_BLK1, tsta_far_inst.DB + 32'h1);
        wr(`TSTA_A_TSC0, 32'h0100_0000);
        wr(`TSTA_A_RXO0, 32'h0);
        tsta_far_inst.send(3'h0, 1'h0, CB + 32'h2, 2);
        tsta_far_inst.send(3'h0, 1'h0, CB + 32'h8, 3);
        tick(1);
        find(`TSTA_A_BLK0, tsta_far_inst.DB + 32'h2);
        wr(`TSTA_A_TSC1, 32'h3);
        tsta_far_inst.send(3'h0, 1'h1, 32'h0, 1);
        waitq(tsta_far_inst.TRL);
        chk({31'h0, bulkStreamFmt}, 32'h1);
        wr(`TSTA_A_CTL, 32'h0000_0040);
        tsta_far_inst.send(3'h1, 1'h0, 32'h0, 1);
        find(`TSTA_A_ISOF, tsta_far_inst.HDR);
        end_sim;
    end
endmodule : testbench
